// ==== src/jcp_pkg.sv ====
// Constants shared by the JTAG configuration port design.
// Assumes a 10-bit instruction register and a system clock of 125 MHz.
package jcp_pkg;
  localparam int IR_WIDTH = 10;
  localparam int DR_WIDTH = 32;
  localparam int ID_WIDTH = 32;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_NS = 64;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [IR_WIDTH-1:0] BYPASS_INSTR = 10'h3ff;
  localparam logic [IR_WIDTH-1:0] SAMPLE_INSTR = 10'h280;
  localparam logic [IR_WIDTH-1:0] EXTEST_INSTR = 10'h281;
  localparam logic [IR_WIDTH-1:0] IDCODE_INSTR = 10'h283;
  localparam logic [IR_WIDTH-1:0] FLOAT_OUTPUTS_INSTR = 10'h285;
  localparam logic [IR_WIDTH-1:0] CONFIG_RESET_INSTR = 10'h28a;
  localparam logic [IR_WIDTH-1:0] CONFIG_LOAD_INSTR = 10'h28b;
  localparam logic [IR_WIDTH-1:0] CONFIG_READBACK_INSTR = 10'h28c;
  localparam logic [IR_WIDTH-1:0] USER_MODE_WAKE_INSTR = 10'h28d;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 10'h001;
  localparam logic [ID_WIDTH-1:0] IDCODE_VALUE = 32'h1234_5001; // Arbitrary value

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jcp_tap_state_type;

  typedef enum logic [4:0] {
    CFG_INIT = 5'h01, CFG_WAIT = 5'h02, CFG_LOAD = 5'h04,
    CFG_WAKE = 5'h08, CFG_USER = 5'h10
  } jcp_cfg_state_type;
endpackage

// ==== src/jcp_cross_if.sv ====
// Signals passing between the TCK domain and the system clock domain.
// Each event is a toggle; the receiver synchronises it itself.
`timescale 1ns/1ns
interface jcp_cross_if;
  logic reset_tgl; // Config reset instruction issued
  logic wake_tgl; // Wake instruction issued
  logic word_tgl; // Config word complete
  logic [31:0] word; // Held stable after word_tgl flips
  logic [31:0] readback; // System-domain readback word, quasi-static
  logic float_req; // Level: float user outputs
  modport tap (output reset_tgl, wake_tgl, word_tgl, word, float_req, input readback);
  modport core (input reset_tgl, wake_tgl, word_tgl, word, float_req, output readback);
endinterface

// ==== src/jcp_tap.sv ====
// TAP controller, instruction register and data registers on TCK.
// Assumes the host supplies TCK and drives TMS/TDI around its rising edge.
`timescale 1ns/1ns
module jcp_tap
  import jcp_pkg::*;
(
  input wire logic tck, // Link clock from host
  input wire logic trst_b, // Async reset, active low
  input wire logic tms, // Mode select
  input wire logic tdi, // Serial data in
  input wire logic chain_first, // Device is first in chain
  output logic tdo, // Serial data out
  output logic tdo_oe_b, // Low while tdo is driven
  output logic flash_access, // Flash reachable through this device
  jcp_cross_if.tap x // Toward system domain
);
  import jcp_pkg::*;
  jcp_tap_state_type tap_state_controller;
  jcp_tap_state_type next_state;
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] ir;
  logic [DR_WIDTH-1:0] dr_shift;
  logic [4:0] bit_cnt;
  logic bypass_bit;

  function automatic logic is_instr(input logic [IR_WIDTH-1:0] v, input logic [IR_WIDTH-1:0] c);
    return v == c;
  endfunction

  always_comb begin
    next_state = tap_state_controller;
    unique case (tap_state_controller)
      TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_state = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_state = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) tap_state_controller <= TAP_RESET;
    else tap_state_controller <= next_state;
  end

  // Instruction register, 10 bits; reset selects the identification register
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      ir_shift <= '0;
      ir <= IDCODE_INSTR;
    end else if (tap_state_controller == TAP_RESET) begin
      ir <= IDCODE_INSTR;
    end else if (tap_state_controller == TAP_CAP_IR) begin
      ir_shift <= IR_CAPTURE_VALUE;
    end else if (tap_state_controller == TAP_SH_IR) begin
      ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
    end else if (tap_state_controller == TAP_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  // Data registers selected by instruction
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      dr_shift <= '0;
      bypass_bit <= 1'b0;
      bit_cnt <= '0;
      x.word_tgl <= 1'b0;
      x.word <= '0;
    end else if (tap_state_controller == TAP_CAP_DR) begin
      bypass_bit <= 1'b0;
      bit_cnt <= '0;
      if (is_instr(ir, IDCODE_INSTR)) dr_shift <= IDCODE_VALUE;
      else if (is_instr(ir, CONFIG_READBACK_INSTR)) dr_shift <= x.readback;
      else dr_shift <= '0;
    end else if (tap_state_controller == TAP_SH_DR) begin
      bypass_bit <= tdi;
      dr_shift <= {tdi, dr_shift[DR_WIDTH-1:1]};
      bit_cnt <= bit_cnt + 5'h01;
      // Full words of bitstream go to the core as they complete
      if (is_instr(ir, CONFIG_LOAD_INSTR) && bit_cnt == 5'h1f) begin
        x.word <= {tdi, dr_shift[DR_WIDTH-1:1]};
        x.word_tgl <= ~x.word_tgl;
      end
    end
  end

  // Config reset and wake instructions act in Update-IR, from the shifted value
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      x.reset_tgl <= 1'b0;
      x.wake_tgl <= 1'b0;
    end else if (tap_state_controller == TAP_UPD_IR) begin
      if (is_instr(ir_shift, CONFIG_RESET_INSTR)) x.reset_tgl <= ~x.reset_tgl;
      if (is_instr(ir_shift, USER_MODE_WAKE_INSTR)) x.wake_tgl <= ~x.wake_tgl;
    end
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) x.float_req <= 1'b0;
    else if (tap_state_controller == TAP_UPD_IR)
      x.float_req <= is_instr(ir_shift, FLOAT_OUTPUTS_INSTR) || is_instr(ir_shift, EXTEST_INSTR);
  end

  // Output changes on falling TCK as boundary scan expects
  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      tdo <= 1'b0;
      tdo_oe_b <= 1'b1;
    end else begin
      tdo_oe_b <= !(tap_state_controller == TAP_SH_DR || tap_state_controller == TAP_SH_IR);
      if (tap_state_controller == TAP_SH_IR) tdo <= ir_shift[0];
      else if (is_instr(ir, BYPASS_INSTR) || is_instr(ir, SAMPLE_INSTR)) tdo <= bypass_bit;
      else tdo <= dr_shift[0];
    end
  end

  assign flash_access = chain_first;
endmodule

// ==== src/jcp_top.sv ====
// JTAG configuration port: TAP on link clock, configuration flow on clock.
// Assumes open-drain pins are resolved outside; enables are active low.
`timescale 1ns/1ns
// Function
// - Configuration reset pin low returns configuration logic to reset.
// - Init flag held low from outside keeps device in initialisation.
// - Init flag released high once rst_b reset ends; it stays released through initialisation.
// - Done line released high once the wake count ends in wake.
// - Done held low externally keeps device out of user mode.
// - TAP state advances on mode select level.
// - Bitstream shifts in on TDI; readback shifts out on TDO.
// - TAP follows standard boundary-scan state sequencing.
// - Logic has TAP controller, instruction register, selected data registers.
// - Decode bypass, sample, extest, idcode and float-outputs instructions.
// - Decode config reset, load, readback and wake instructions.
// - Only first device in a chain gives flash access.
// - Before mode sampling, low init flag delays configuration.
// - After mode sampling, init flag drives low on error and is released otherwise.
module jcp_top
  import jcp_pkg::*;
#(
  parameter int WAKE_CNT = WAKE_CYCLES
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes system-domain state when low
  input wire logic cfg_logic_reset_n, // Configuration reset pin
  input wire logic tck, // Test clock from host
  input wire logic tms, // Test mode select
  input wire logic tdi, // Test data in
  output logic tdo, // Test data out
  output logic tdo_oe_b, // Low while tdo is driven
  input wire logic chain_first, // Strap: first device in chain
  output logic flash_access, // Flash port enabled
  input wire logic init_flag_in, // Init flag pin level
  output logic init_flag_out, // Always low; pin driven when enabled
  output logic init_flag_oe_b, // Low pulls init flag low
  input wire logic done_in, // Done pin level
  output logic done_out, // Always low; pin driven when enabled
  output logic done_oe_b, // Low pulls done low
  input wire logic cfg_error, // Configuration error from loader
  output logic cfg_word_valid, // One-cycle pulse per bitstream word received while in CFG_LOAD
  output logic [31:0] cfg_word, // Bitstream word
  input wire logic [31:0] readback_word, // Readback data from fabric
  output logic user_mode, // Device in user mode
  output logic outputs_float // User outputs float
);
  import jcp_pkg::*;
  jcp_cross_if x();
  jcp_cfg_state_type state;
  logic cfg_rst_b;
  logic tap_rst_b;
  logic [1:0] rst_sync;
  logic [1:0] init_sync;
  logic [1:0] done_sync;
  logic [1:0] float_sync;
  logic [2:0] reset_sync;
  logic [2:0] wake_sync;
  logic [2:0] word_sync;
  logic wake_pend;
  logic [15:0] wake_cnt;
  logic err_flag;

  function automatic logic tgl_edge(input logic [2:0] s);
    return s[2] ^ s[1];
  endfunction

  assign tap_rst_b = rst_b;

  jcp_tap u_tap (
    .tck(tck),
    .trst_b(tap_rst_b),
    .tms(tms),
    .tdi(tdi),
    .chain_first(chain_first),
    .tdo(tdo),
    .tdo_oe_b(tdo_oe_b),
    .flash_access(flash_access),
    .x(x.tap)
  );

  // Readback word is held by the fabric while the host captures it
  assign x.readback = readback_word;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
      init_sync <= 2'h0;
      done_sync <= 2'h0;
      float_sync <= 2'h0;
      reset_sync <= 3'h0;
      wake_sync <= 3'h0;
      word_sync <= 3'h0;
    end else if (clk_en) begin
      rst_sync <= {rst_sync[0], cfg_logic_reset_n};
      init_sync <= {init_sync[0], init_flag_in};
      done_sync <= {done_sync[0], done_in};
      float_sync <= {float_sync[0], x.float_req};
      reset_sync <= {reset_sync[1:0], x.reset_tgl};
      wake_sync <= {wake_sync[1:0], x.wake_tgl};
      word_sync <= {word_sync[1:0], x.word_tgl};
    end
  end

  // Pin reset or the reset instruction both restart configuration
  assign cfg_rst_b = rst_sync[1] && !tgl_edge(reset_sync);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= CFG_INIT;
    end else if (clk_en) begin
      if (!cfg_rst_b) state <= CFG_INIT;
      else begin
        unique case (state)
          CFG_INIT: if (init_sync[1]) state <= CFG_WAIT;
          CFG_WAIT: state <= CFG_LOAD;
          CFG_LOAD: if (wake_pend) state <= CFG_WAKE;
          CFG_WAKE: if (wake_cnt == 16'h0 && done_sync[1]) state <= CFG_USER;
          CFG_USER: state <= CFG_USER;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wake_pend <= 1'b0;
    else if (clk_en) begin
      if (tgl_edge(wake_sync)) wake_pend <= 1'b1;
      else if (!cfg_rst_b || state == CFG_WAKE) wake_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wake_cnt <= 16'h0;
    else if (clk_en) begin
      if (state != CFG_WAKE) wake_cnt <= 16'(WAKE_CNT);
      else if (wake_cnt != 16'h0) wake_cnt <= wake_cnt - 16'h1;
    end
  end

  // Error sticks until configuration restarts; set wins over clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) err_flag <= 1'b0;
    else if (clk_en) begin
      if (cfg_error && state != CFG_INIT) err_flag <= 1'b1;
      else if (!cfg_rst_b) err_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_word_valid <= 1'b0;
      cfg_word <= 32'h0;
    end else if (clk_en) begin
      cfg_word_valid <= tgl_edge(word_sync) && state == CFG_LOAD;
      if (tgl_edge(word_sync)) cfg_word <= x.word;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_flag_oe_b <= 1'b0;
      done_oe_b <= 1'b0;
      user_mode <= 1'b0;
      outputs_float <= 1'b1;
    end else if (clk_en) begin
      // Released during init so the pin is an input; low on error after
      init_flag_oe_b <= !(state != CFG_INIT && err_flag);
      // Released once the wake count ends so the pin can be read back;
      // an outside low then holds the flow in wake
      done_oe_b <= state == CFG_USER || (state == CFG_WAKE && wake_cnt == 16'h0);
      user_mode <= state == CFG_USER;
      outputs_float <= state != CFG_USER || float_sync[1];
    end
  end

  assign init_flag_out = 1'b0;
  assign done_out = 1'b0;
endmodule

// ==== verif/jcp_host.sv ====
// Host model for the JTAG link: drives test clock, mode select, data in.
// Assumes tdo moves on the falling test clock edge.
`timescale 1ns/1ns
module jcp_host (
  output logic tck, // Test clock, still between frames
  output logic tms, // Mode select
  output logic tdi, // Serial data in
  input wire logic tdo // Serial data out
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One 64 ns period; tdo taken at the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16 tck = 1'b1;
    q = tdo;
    #32 tck = 1'b0;
    #16;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // Idle to idle through one shift of n bits, LSB first
  task automatic shift(input logic ir, input logic [63:0] din, input int n,
                       output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ==== verif/jcp_top_checker.sv ====
// Concurrent checks on the configuration port's top-level pins.
// Assumes a bind onto jcp_top; each domain has its own clock.
`timescale 1ns/1ns
module jcp_top_checker #(
  parameter int WAKE_CNT = 8
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic cfg_logic_reset_n, // Config reset pin
  input wire logic tck, // Test clock
  input wire logic tms, // Mode select
  input wire logic tdo_oe_b, // Data out enable
  input wire logic chain_first, // Chain strap
  input wire logic flash_access, // Flash reach
  input wire logic init_flag_out, // Init flag drive
  input wire logic init_flag_oe_b, // Init flag enable
  input wire logic done_in, // Done pin level
  input wire logic done_out, // Done drive
  input wire logic done_oe_b, // Done enable
  input wire logic cfg_error, // Loader error
  input wire logic cfg_word_valid, // Word strobe
  input wire logic user_mode // User mode
);
  AST_DONE_USER: assert property (@(posedge clock) disable iff (!rst_b)
    user_mode |-> done_oe_b && done_in) else $error("user mode without done high");
  AST_DONE_FIRST: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(done_oe_b) |-> !user_mode) else $error("done released after user mode");
  AST_DONE_HELD: assert property (@(posedge clock) disable iff (!rst_b)
    !done_in [*5] |-> !$rose(user_mode)) else $error("user mode with done held low");
  AST_RST_PIN: assert property (@(posedge clock) disable iff (!rst_b)
    !cfg_logic_reset_n [*5] |-> !user_mode && !done_oe_b) else $error("pin reset ignored");
  AST_OD_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    !init_flag_out && !done_out) else $error("open-drain pin driven high");
  AST_FLASH: assert property (@(posedge clock) disable iff (!rst_b)
    flash_access == chain_first) else $error("flash access not from chain strap");
  AST_WORD_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_word_valid |=> !cfg_word_valid [*8]) else $error("word strobes too close");
  AST_TAP_RESET: assert property (@(posedge tck) disable iff (!rst_b)
    tms [*5] |=> tdo_oe_b) else $error("data out enabled after five mode highs");
  AST_ERR_CAUSE: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(init_flag_oe_b) |-> $past(cfg_error) || $past(cfg_error, 2) || $past(cfg_error, 3))
    else $error("error flag without error");
  AST_ERR_SEEN: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_error && user_mode |-> ##[1:3] !init_flag_oe_b) else $error("error not flagged");
endmodule
bind jcp_top jcp_top_checker #(.WAKE_CNT(WAKE_CNT)) i_jcp_top_checker (
  .clock, .rst_b, .cfg_logic_reset_n, .tck, .tms, .tdo_oe_b, .chain_first,
  .flash_access, .init_flag_out, .init_flag_oe_b, .done_in, .done_out,
  .done_oe_b, .cfg_error, .cfg_word_valid, .user_mode
);

// ==== verif/tb_top.sv ====
// Self-checking bench for the JTAG configuration port.
// Assumes the host model runs the link; open-drain pins resolve here.
`timescale 1ns/1ns
module tb_top;
  import jcp_pkg::*;
  typedef struct {logic [9:0] instr; logic [63:0] din; int n; logic [63:0] exp;} jcp_row_type;
  logic clock, rst_b, clk_en, cfg_logic_reset_n, tck, tms, tdi, tdo, tdo_oe_b;
  logic chain_first, flash_access, init_flag_in, init_flag_out, init_flag_oe_b;
  logic done_in, done_out, done_oe_b, cfg_error, cfg_word_valid, user_mode, outputs_float;
  logic init_ext, done_ext;
  logic [31:0] cfg_word, readback_word, last_word;
  logic [63:0] got;
  int bad_count, compares, words, cycles;
  jcp_row_type rows[7];
  assign init_flag_in = init_flag_oe_b ? init_ext : init_flag_out;
  assign done_in = done_oe_b ? done_ext : done_out;
  jcp_top #(.WAKE_CNT(2)) i_jcp_top (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .cfg_logic_reset_n(cfg_logic_reset_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_b(tdo_oe_b),
    .chain_first(chain_first), .flash_access(flash_access), .init_flag_in(init_flag_in),
    .init_flag_out(init_flag_out), .init_flag_oe_b(init_flag_oe_b), .done_in(done_in),
    .done_out(done_out), .done_oe_b(done_oe_b), .cfg_error(cfg_error),
    .cfg_word_valid(cfg_word_valid), .cfg_word(cfg_word), .readback_word(readback_word),
    .user_mode(user_mode), .outputs_float(outputs_float)
  );
  jcp_host i_jcp_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ir(input logic [9:0] c);
    i_jcp_host.shift(1'b1, {54'h0, c}, 10, got);
    chk(got, {54'h0, IR_CAPTURE_VALUE});
  endtask
  task automatic dr(input logic [63:0] d, input int n);
    i_jcp_host.shift(1'b0, d, n, got);
  endtask
  // Cycle ceiling against a hung handshake
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cfg_word_valid === 1'b1) begin
      words <= words + 1;
      last_word <= cfg_word;
    end
    if (cycles == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    cfg_logic_reset_n = 1'b1;
    chain_first = 1'b0;
    init_ext = 1'b0;
    done_ext = 1'b1;
    cfg_error = 1'b0;
    readback_word = 32'hc3a5_0f96;
    bad_count = 0;
    compares = 0;
    words = 0;
    cycles = 0;
    rows = '{'{IDCODE_INSTR, 64'h0, 32, {32'h0, IDCODE_VALUE}},
      '{BYPASS_INSTR, 64'h5, 8, 64'ha},
      '{CONFIG_READBACK_INSTR, 64'h0, 32, {32'h0, readback_word}},
      '{SAMPLE_INSTR, 64'h0, 0, 64'h0}, '{EXTEST_INSTR, 64'h0, 0, 64'h0},
      '{FLOAT_OUTPUTS_INSTR, 64'h0, 0, 64'h0}, '{CONFIG_RESET_INSTR, 64'h0, 0, 64'h0}};
    // One test clock edge must land inside reset
    fork
      i_jcp_host.step(1'b1, 1'b1, got[0]);
      repeat (16) @(posedge clock);
    join
    rst_b <= 1'b1;
    i_jcp_host.tap_reset();
    @(posedge clock);
    chk(flash_access, 1'b0);
    chk(init_flag_oe_b, 1'b1);
    chain_first <= 1'b1;
    @(posedge clock);
    chk(flash_access, 1'b1);
    foreach (rows[i]) begin
      ir(rows[i].instr);
      if (rows[i].n > 0) begin
        dr(rows[i].din, rows[i].n);
        chk(got, rows[i].exp);
      end
    end
    ir(CONFIG_LOAD_INSTR);
    dr(64'h1357_9bdf, 32);
    repeat (8) @(posedge clock);
    chk(words, 0);
    init_ext <= 1'b1;
    repeat (8) @(posedge clock);
    ir(CONFIG_LOAD_INSTR);
    dr(64'hfeed_5a5a_1357_9bdf, 40);
    repeat (8) @(posedge clock);
    chk({words, last_word}, {32'd1, 32'h1357_9bdf});
    dr(64'h0f1e_2d3c_4b5a_6978, 64);
    repeat (8) @(posedge clock);
    chk({words, last_word}, {32'd3, 32'h0f1e_2d3c});
    done_ext <= 1'b0;
    ir(USER_MODE_WAKE_INSTR);
    repeat (40) @(posedge clock);
    chk(user_mode, 1'b0);
    clk_en <= 1'b0;
    done_ext <= 1'b1;
    repeat (40) @(posedge clock);
    chk(user_mode, 1'b0);
    clk_en <= 1'b1;
    repeat (40) @(posedge clock);
    chk({user_mode, done_oe_b, outputs_float}, 3'b110);
    ir(FLOAT_OUTPUTS_INSTR);
    repeat (8) @(posedge clock);
    chk(outputs_float, 1'b1);
    cfg_error <= 1'b1;
    repeat (4) @(posedge clock);
    chk(init_flag_oe_b, 1'b0);
    cfg_error <= 1'b0;
    cfg_logic_reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk({user_mode, done_oe_b}, 2'b00);
    cfg_logic_reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk(init_flag_oe_b, 1'b1);
    end_sim();
  end
endmodule
